/* logic/rtdt_byte_lane.sv */
// Two-byte highway sequencer, high byte first
`include "rtdt_defs.svh"
module rtdt_byte_lane (
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_start,
   input  wire logic        i_transmit,
   input  wire logic [15:0] i_word,
   input  wire logic [7:0]  i_highway,
   output logic [7:0]       o_highway,
   output logic             o_highway_oe,
   output logic             o_byte_transfer_strobe,
   output logic             o_high_byte,
   output logic [15:0]      o_word,
   output logic             o_done
);
   import rtdt_pkg::*;
   localparam int STB = `RTDT_STB_CYC;
   logic [2:0]  phase;
   logic [1:0]  cnt;
   logic [15:0] hold;
   // Phase 1,2 = high byte setup/strobe; 3,4 = low byte; 5 = tail with highway off; data set up one phase before each strobe
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         phase <= 3'h0;
         cnt   <= 2'h0;
      end else if (phase == 3'h0) begin
         if (i_start) begin
            phase <= 3'h1;
            cnt   <= 2'h0;
         end
      end else if (cnt == 2'(STB - 1)) begin
         cnt   <= 2'h0;
         phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         hold   <= 16'h0000;
         o_word <= 16'h0000;
      end else begin
         if (i_start && phase == 3'h0)
            hold <= i_word;
         // Latch on the strobe's closing cycle
         if (i_transmit && phase == 3'h2 && cnt == 2'(STB - 1))
            o_word[15:8] <= i_highway;
         if (i_transmit && phase == 3'h4 && cnt == 2'(STB - 1))
            o_word[7:0] <= i_highway;
      end
   end
   assign o_byte_transfer_strobe = (phase == 3'h2) || (phase == 3'h4);
   assign o_high_byte            = (phase == 3'h1) || (phase == 3'h2);
   assign o_highway_oe           = !i_transmit && (phase != 3'h0) && (phase != 3'h5);
   assign o_highway              = o_high_byte ? hold[15:8] : hold[7:0];
   assign o_done                 = (phase == 3'h5) && (cnt == 2'(STB - 1));
endmodule : rtdt_byte_lane

/* logic/rtdt_defs.svh */
// Constants for the remote terminal data-transfer block
`ifndef RTDT_DEFS_SVH
`define RTDT_DEFS_SVH
`define RTDT_CLK_MHZ         50
`define RTDT_WORD_GAP_NS     20000
`define RTDT_WORD_GAP_CYC    ((`RTDT_WORD_GAP_NS * `RTDT_CLK_MHZ) / 1000)
`define RTDT_RX_ACK_NS       1500
`define RTDT_RX_ACK_CYC      ((`RTDT_RX_ACK_NS * `RTDT_CLK_MHZ) / 1000)
`define RTDT_TX_ACK_NS       13500
`define RTDT_TX_ACK_CYC      ((`RTDT_TX_ACK_NS * `RTDT_CLK_MHZ) / 1000)
`define RTDT_STB_CYC         2
`define RTDT_BCAST_ADDR      5'h1f
`define RTDT_MAX_WORDS       32
`endif

/* logic/rtdt_pkg.sv */
// Types for the remote terminal data-transfer block
package rtdt_pkg;
   typedef struct packed {
      logic       valid;
      logic       code_ok;
      logic       parity_ok;
      logic [4:0] address;
      logic       transmit;
      logic [4:0] subaddress;
      logic [4:0] word_count;
   } rtdt_cmd_t;
   typedef struct packed {
      logic        valid;
      logic        good;
      logic [15:0] data;
   } rtdt_word_t;
   typedef enum logic [2:0] {
      RTDT_IDLE   = 3'b000,
      RTDT_WAIT   = 3'b001,
      RTDT_ACK    = 3'b010,
      RTDT_BYTES  = 3'b011,
      RTDT_GAP    = 3'b100
   } rtdt_state_t;
endpackage : rtdt_pkg

/* logic/rtdt_transfer.sv */
// Remote terminal data transfer between protocol core and subsystem
`include "rtdt_defs.svh"
module rtdt_transfer #(
   parameter int WORD_GAP_CYC = `RTDT_WORD_GAP_CYC,
   parameter int RX_ACK_CYC   = `RTDT_RX_ACK_CYC,
   parameter int TX_ACK_CYC   = `RTDT_TX_ACK_CYC
) (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rstn,
   input  wire rtdt_pkg::rtdt_cmd_t   i_cmd,
   input  wire logic [4:0]            i_own_address,
   input  wire logic                  i_broadcast_enable,
   input  wire rtdt_pkg::rtdt_word_t  i_rx_word,
   input  wire logic                  i_rx_end,
   input  wire logic                  i_msg_error,
   input  wire logic                  i_bus_switch,
   input  wire logic                  i_tx_word_start,
   input  wire logic                  i_subsystem_busy,
   input  wire logic                  i_word_acknowledge_n,
   input  wire logic [7:0]            i_byte_highway,
   output logic                       o_command_accepted_pulse_n,
   output logic                       o_transmit,
   output logic                       o_word_request_n,
   output logic                       o_byte_transfer_strobe,
   output logic                       o_high_byte,
   output logic [7:0]                 o_byte_highway,
   output logic                       o_byte_highway_oe,
   output logic                       o_good_block_pulse_n,
   output logic [15:0]                o_tx_word,
   output logic                       o_tx_word_valid,
   output logic                       o_subsystem_failure,
   output logic [5:0]                 o_current_word_count
);
   import rtdt_pkg::*;
   rtdt_state_t state;
   rtdt_state_t next_state;
   logic        active;
   logic        rx_pending;
   logic [15:0] rx_data;
   logic        msg_bad;
   logic [5:0]  expect_cnt;
   logic [19:0] timer;
   logic        lane_done;
   logic        tx_req_due;
   logic [15:0] lane_word;
   // ------------------------------------------------------------
   // Command acceptance
   // ------------------------------------------------------------
   function automatic logic cmd_for_us(input rtdt_cmd_t c, input logic [4:0] own,
                                       input logic bcast);
      cmd_for_us = c.valid && c.code_ok && c.parity_ok &&
                   ((c.address == own) || (bcast && c.address == `RTDT_BCAST_ADDR));
   endfunction : cmd_for_us
   logic accept;
   assign accept = cmd_for_us(i_cmd, i_own_address, i_broadcast_enable);
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         active                     <= 1'b0;
         o_transmit                 <= 1'b0;
         expect_cnt                 <= 6'h00;
         o_command_accepted_pulse_n <= 1'b1;
      end else begin
         o_command_accepted_pulse_n <= !accept;
         if (accept) begin
            active     <= 1'b1;
            o_transmit <= i_cmd.transmit;
            // Zero word count means the full block
            expect_cnt <= (i_cmd.word_count == 5'h00) ? 6'(`RTDT_MAX_WORDS)
                                                      : {1'b0, i_cmd.word_count};
         end else if (i_rx_end || (o_transmit && o_current_word_count == expect_cnt &&
                                   state == RTDT_IDLE)) begin
            active <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------
   // Receive word capture and block validity
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_pending <= 1'b0;
         rx_data    <= 16'h0000;
      end else if (accept) begin
         rx_pending <= 1'b0;
      end else if (active && !o_transmit && i_rx_word.valid && i_rx_word.good) begin
         rx_pending <= 1'b1;
         rx_data    <= i_rx_word.data;
      end else if (state == RTDT_IDLE && rx_pending) begin
         rx_pending <= 1'b0;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         msg_bad <= 1'b0;
      end else if (accept && !i_bus_switch) begin
         msg_bad <= 1'b0;
      end else if (i_msg_error || i_bus_switch || o_subsystem_failure ||
                   (i_rx_word.valid && !i_rx_word.good)) begin
         msg_bad <= 1'b1;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_good_block_pulse_n <= 1'b1;
      end else begin
         // One-cycle low pulse, count checked and no error seen
         // End may fall while the last word's spacing runs out; it must not be lost
         o_good_block_pulse_n <= !(i_rx_end && active && !o_transmit && !msg_bad &&
                                   !i_msg_error && !i_bus_switch && !rx_pending &&
                                   (state == RTDT_IDLE || state == RTDT_GAP) &&
                                   o_current_word_count == expect_cnt);
      end
   end
   // ------------------------------------------------------------
   // Handshake sequencer
   // ------------------------------------------------------------
   assign tx_req_due = active && o_transmit && (o_current_word_count < expect_cnt);
   always_comb begin
      next_state = state;
      case (state)
         RTDT_IDLE: begin
            if (active && !o_transmit && rx_pending)
               next_state = RTDT_ACK;
            else if (tx_req_due)
               next_state = RTDT_ACK;
         end
         RTDT_ACK: begin
            if (!i_word_acknowledge_n)
               next_state = RTDT_BYTES;
            else if (timer == 20'h00000)
               next_state = RTDT_IDLE;
         end
         RTDT_BYTES: begin
            if (lane_done)
               next_state = o_transmit ? RTDT_WAIT : RTDT_GAP;
         end
         RTDT_WAIT: begin
            // Next request only once the current word starts on the bus
            if (i_tx_word_start || !active)
               next_state = RTDT_IDLE;
         end
         RTDT_GAP: begin
            if (timer == 20'h00000)
               next_state = RTDT_IDLE;
         end
         default: next_state = RTDT_IDLE;
      endcase
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= RTDT_IDLE;
      end else if (accept || i_bus_switch) begin
         state <= RTDT_IDLE;
      end else begin
         state <= next_state;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         timer <= 20'h00000;
      end else if (state == RTDT_IDLE && next_state == RTDT_ACK) begin
         timer <= o_transmit ? 20'(TX_ACK_CYC - 1) : 20'(RX_ACK_CYC - 1);
      end else if (state == RTDT_BYTES && lane_done) begin
         timer <= 20'(WORD_GAP_CYC - 1);
      end else if (timer != 20'h00000) begin
         timer <= timer - 20'h00001;
      end
   end
   // ------------------------------------------------------------
   // Failure flag and word count
   // ------------------------------------------------------------
   // A timeout beats a clearing command in the same cycle
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_subsystem_failure <= 1'b0;
      end else if (state == RTDT_ACK && i_word_acknowledge_n && timer == 20'h00000 &&
                   (o_transmit || !i_subsystem_busy)) begin
         o_subsystem_failure <= 1'b1;
      end else if (accept) begin
         o_subsystem_failure <= 1'b0;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_current_word_count <= 6'h00;
      end else if (accept) begin
         o_current_word_count <= 6'h00;
      end else if (state == RTDT_BYTES && lane_done) begin
         o_current_word_count <= o_current_word_count + 6'h01;
      end
   end
   // ------------------------------------------------------------
   // Transmit word toward the protocol core
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tx_word_valid <= 1'b0;
         o_tx_word       <= 16'h0000;
      end else begin
         o_tx_word_valid <= state == RTDT_BYTES && lane_done && o_transmit;
         if (state == RTDT_BYTES && lane_done && o_transmit)
            o_tx_word <= lane_word;
      end
   end
   // ------------------------------------------------------------
   // Request strobe and byte lane
   // ------------------------------------------------------------
   assign o_word_request_n = !((state == RTDT_ACK) || (state == RTDT_BYTES));
   rtdt_byte_lane u_lane (
      .i_core_clk             (i_core_clk),
      .i_rstn                 (i_rstn),
      .i_start                (state == RTDT_ACK && !i_word_acknowledge_n),
      .i_transmit             (o_transmit),
      .i_word                 (rx_data),
      .i_highway              (i_byte_highway),
      .o_highway              (o_byte_highway),
      .o_highway_oe           (o_byte_highway_oe),
      .o_byte_transfer_strobe (o_byte_transfer_strobe),
      .o_high_byte            (o_high_byte),
      .o_word                 (lane_word),
      .o_done                 (lane_done)
   );
endmodule : rtdt_transfer

/* sim/rtdt_host_model.sv */
// Host subsystem model: answers word requests and moves bytes on the highway
module rtdt_host_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_word_request_n,
   input  wire logic        i_transmit,
   input  wire logic        i_high_byte,
   input  wire logic        i_strobe,
   input  wire logic [7:0]  i_highway,
   input  wire logic        i_highway_oe,
   input  wire logic [7:0]  i_ack_delay,
   input  wire logic [15:0] i_tx_word,
   output logic             o_ack_n,
   output logic [7:0]       o_highway,
   output logic [15:0]      o_rx_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] wait_cnt;
   // A delay of 8'hff never answers, to provoke a failure
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wait_cnt <= 8'h00;
         o_ack_n  <= 1'b1;
      end else if (i_word_request_n) begin
         wait_cnt <= 8'h00;
         o_ack_n  <= 1'b1;
      end else if (wait_cnt == i_ack_delay && i_ack_delay != 8'hff) begin
         o_ack_n <= 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end
   // Outside a transmit word the lines show the inverse, never a stale byte
   assign o_highway = (!i_word_request_n && i_transmit && !o_ack_n) ?
      (i_high_byte ? i_tx_word[15:8] : i_tx_word[7:0]) : ~i_tx_word[7:0];
   // Holds one word only; the bench reads it before the next arrives
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rx_word <= 16'h0000;
      end else if (i_strobe && i_highway_oe && !i_word_request_n) begin
         if (i_high_byte) begin
            o_rx_word[15:8] <= i_highway;
         end else begin
            o_rx_word[7:0] <= i_highway;
         end
      end
   end
endmodule : rtdt_host_model

/* sim/rtdt_transfer_chk.sv */
// Port-level checker for the transfer block
module rtdt_transfer_chk #(
   parameter int RX_ACK_CYC = 5
) (
   input wire logic                i_core_clk,
   input wire logic                i_rstn,
   input wire rtdt_pkg::rtdt_cmd_t i_cmd,
   input wire logic [4:0]          i_own_address,
   input wire logic                i_broadcast_enable,
   input wire logic                i_rx_end,
   input wire logic                i_msg_error,
   input wire logic                i_bus_switch,
   input wire logic                i_subsystem_busy,
   input wire logic                i_word_acknowledge_n,
   input wire logic                o_command_accepted_pulse_n,
   input wire logic                o_transmit,
   input wire logic                o_word_request_n,
   input wire logic                o_byte_transfer_strobe,
   input wire logic                o_high_byte,
   input wire logic [7:0]          o_byte_highway,
   input wire logic                o_byte_highway_oe,
   input wire logic                o_good_block_pulse_n,
   input wire logic                o_subsystem_failure
);
   import rtdt_pkg::*;
   logic       hit;
   logic [7:0] wait_cnt;
   assign hit = i_cmd.valid && i_cmd.code_ok && i_cmd.parity_ok && (i_cmd.address ==
      i_own_address || (i_cmd.address == 5'h1f && i_broadcast_enable));
   // Busy excuses a slow answer, so it clears the count
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wait_cnt <= 8'h00;
      end else if (!o_word_request_n && i_word_acknowledge_n && !o_transmit &&
                   !i_subsystem_busy) begin
         wait_cnt <= wait_cnt + 8'h01;
      end else begin
         wait_cnt <= 8'h00;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   chk_accept_pulse: assert property (hit |=> !o_command_accepted_pulse_n)
      else $error("accepted command without pulse");
   chk_refuse_other: assert property (!hit |=> o_command_accepted_pulse_n)
      else $error("pulse without accepted command");
   chk_good_cause: assert property (!o_good_block_pulse_n |->
      $past(i_rx_end) && !$past(i_msg_error) && !$past(i_bus_switch))
      else $error("good block without clean end");
   chk_good_single: assert property (!o_good_block_pulse_n |=> o_good_block_pulse_n)
      else $error("good block longer than one cycle");
   chk_strobe_width: assert property ($rose(o_byte_transfer_strobe) |->
      o_byte_transfer_strobe[*2] ##1 !o_byte_transfer_strobe)
      else $error("strobe not two cycles");
   chk_high_first: assert property ($rose(o_byte_transfer_strobe) && o_high_byte |->
      ##4 (o_byte_transfer_strobe && !o_high_byte))
      else $error("low byte strobe missing after high");
   chk_byte_stable: assert property (o_byte_transfer_strobe && o_byte_highway_oe |->
      $stable(o_byte_highway))
      else $error("highway moved under strobe");
   chk_ack_timeout: assert property (wait_cnt == 8'(RX_ACK_CYC) |->
      o_subsystem_failure)
      else $error("missing acknowledge not flagged");
endmodule : rtdt_transfer_chk

bind rtdt_transfer rtdt_transfer_chk #(.RX_ACK_CYC(RX_ACK_CYC)) rtdt_transfer_chk_i (
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cmd(i_cmd), .i_own_address(i_own_address),
   .i_broadcast_enable(i_broadcast_enable), .i_rx_end(i_rx_end), .i_msg_error(i_msg_error),
   .i_bus_switch(i_bus_switch), .i_subsystem_busy(i_subsystem_busy),
   .i_word_acknowledge_n(i_word_acknowledge_n), .o_transmit(o_transmit),
   .o_command_accepted_pulse_n(o_command_accepted_pulse_n),
   .o_word_request_n(o_word_request_n), .o_byte_transfer_strobe(o_byte_transfer_strobe),
   .o_high_byte(o_high_byte), .o_byte_highway(o_byte_highway),
   .o_byte_highway_oe(o_byte_highway_oe), .o_good_block_pulse_n(o_good_block_pulse_n),
   .o_subsystem_failure(o_subsystem_failure));

/* sim/tb_rtdt_transfer.sv */
// Testbench for the transfer block against the host model
module tb_rtdt_transfer;
   timeunit 1ns;
   timeprecision 1ns;
   import rtdt_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, rx_end = 1'b0, err = 1'b0, sw = 1'b0, txs = 1'b0;
   logic busy = 1'b0, bcast = 1'b0, acc_n, tx, req_n, stb, hi, oe, good_n, txv, fail, ack_n;
   logic [7:0]  dly = 8'h02, hw_o, hw_i;
   logic [15:0] txw = 16'hc35a, txo, rxo;
   logic [5:0]  cnt;
   rtdt_cmd_t   cmd = '0;
   rtdt_word_t  rxw = '0;
   int num_errors = 0, total_checks = 0;
   always #10 clk = ~clk;
   rtdt_transfer #(.WORD_GAP_CYC(20), .RX_ACK_CYC(5), .TX_ACK_CYC(10)) rtdt_transfer_i (
      .i_core_clk(clk), .i_rstn(rstn), .i_cmd(cmd), .i_own_address(5'h0a),
      .i_broadcast_enable(bcast), .i_rx_word(rxw), .i_rx_end(rx_end), .i_msg_error(err),
      .i_bus_switch(sw), .i_tx_word_start(txs), .i_subsystem_busy(busy),
      .i_word_acknowledge_n(ack_n), .i_byte_highway(hw_i), .o_command_accepted_pulse_n(acc_n),
      .o_transmit(tx), .o_word_request_n(req_n), .o_byte_transfer_strobe(stb),
      .o_high_byte(hi), .o_byte_highway(hw_o), .o_byte_highway_oe(oe),
      .o_good_block_pulse_n(good_n), .o_tx_word(txo), .o_tx_word_valid(txv),
      .o_subsystem_failure(fail), .o_current_word_count(cnt));
   rtdt_host_model rtdt_host_model_i (.i_core_clk(clk), .i_rstn(rstn),
      .i_word_request_n(req_n), .i_transmit(tx), .i_high_byte(hi), .i_strobe(stb),
      .i_highway(hw_o), .i_highway_oe(oe), .i_ack_delay(dly), .i_tx_word(txw),
      .o_ack_n(ack_n), .o_highway(hw_i), .o_rx_word(rxo));
   task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: exp %h got %h", $time, e, g);
      end
   endtask : chk_word
   task automatic send_cmd(input logic [4:0] a, input logic t, input logic [4:0] w,
                           input logic ok, input logic [15:0] e);
      logic [15:0] lows;
      lows = 16'h0000;
      cmd = '{1'b1, 1'b1, ok, a, t, 5'h01, w};
      @(negedge clk);
      cmd.valid = 1'b0;
      // The pulse stands only in the cycle right after acceptance
      lows = 16'(acc_n === 1'b0);
      repeat (2) begin
         @(negedge clk);
         lows += 16'(acc_n === 1'b0);
      end
      chk_word(e, lows);
   endtask : send_cmd
   task automatic send_word(input logic [15:0] d);
      int k;
      rxw = '{1'b1, 1'b1, d};
      @(negedge clk);
      rxw.valid = 1'b0;
      for (k = 0; k < 40 && req_n !== 1'b0; k++) @(negedge clk);
      for (k = 0; k < 60 && req_n !== 1'b1; k++) @(negedge clk);
      chk_word(d, rxo);
      repeat (10) @(negedge clk);
   endtask : send_word
   task automatic rx_msg(input int n, input logic e, input logic s, input logic [15:0] g);
      logic [15:0] lows;
      lows = 16'h0000;
      send_cmd(5'h0a, 1'b0, 5'(n), 1'b1, 16'h0001);
      chk_word(16'h0000, 16'(cnt));
      for (int i = 0; i < n; i++) send_word(16'h9a00 + 16'(i));
      chk_word(16'(n), 16'(cnt));
      err = e;
      sw = s;
      @(negedge clk);
      err = 1'b0;
      sw = 1'b0;
      rx_end = 1'b1;
      @(negedge clk);
      rx_end = 1'b0;
      lows = 16'(good_n === 1'b0);
      repeat (3) begin
         @(negedge clk);
         lows += 16'(good_n === 1'b0);
      end
      chk_word(g, lows);
      $display("test rx_msg done");
   endtask : rx_msg
   task automatic test_other;
      send_cmd(5'h0b, 1'b0, 5'h01, 1'b1, 16'h0000);
      send_cmd(5'h0a, 1'b0, 5'h01, 1'b0, 16'h0000);
      send_cmd(5'h1f, 1'b0, 5'h01, 1'b1, 16'h0000);
      rxw = '{1'b1, 1'b1, 16'h5555};
      @(negedge clk);
      rxw.valid = 1'b0;
      repeat (3) @(negedge clk);
      chk_word(16'h0001, 16'(req_n));
      bcast = 1'b1;
      send_cmd(5'h1f, 1'b0, 5'h01, 1'b1, 16'h0001);
      bcast = 1'b0;
      $display("test addressing done");
   endtask : test_other
   task automatic test_fail;
      dly = 8'hff;
      busy = 1'b1;
      send_cmd(5'h0a, 1'b0, 5'h01, 1'b1, 16'h0001);
      rxw = '{1'b1, 1'b1, 16'h1234};
      @(negedge clk);
      rxw.valid = 1'b0;
      repeat (20) @(negedge clk);
      chk_word(16'h0000, 16'(fail));
      busy = 1'b0;
      // The excused word was dropped; a fresh word must now time out
      rxw = '{1'b1, 1'b1, 16'h4321};
      @(negedge clk);
      rxw.valid = 1'b0;
      repeat (20) @(negedge clk);
      chk_word(16'h0001, 16'(fail));
      dly = 8'h06;
      $display("test failure done");
   endtask : test_fail
   task automatic test_tx;
      int k;
      send_cmd(5'h0a, 1'b1, 5'h02, 1'b1, 16'h0001);
      chk_word(16'h0002, 16'({tx, fail}));
      repeat (2) begin
         for (k = 0; k < 100 && txv !== 1'b1; k++) @(negedge clk);
         chk_word(txw, txo);
         txw = ~txw;
         txs = 1'b1;
         @(negedge clk);
         txs = 1'b0;
      end
      chk_word(16'h0000, 16'(fail));
      $display("test transmit done");
   endtask : test_tx
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   initial begin
      #400000;
      num_errors++;
      test_done();
   end
   initial begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      test_other();
      rx_msg(2, 1'b0, 1'b0, 16'h0001);
      rx_msg(1, 1'b1, 1'b0, 16'h0000);
      rx_msg(1, 1'b0, 1'b1, 16'h0000);
      test_fail();
      test_tx();
      test_done();
   end
endmodule : tb_rtdt_transfer
